// ==== verilog/timer8_compare_irq_regs.v ====
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "timer8_regs.vh"
// register side of an 8-bit timer: two compare values, a running
// counter, three sticky event flags with enables and level requests
// limitation: compare output modes are not modelled, pins just toggle
// trade-off: counter and prescaler are minimal, enough to make events
// every register sits in byte lane 0 of a 32-bit bus word
module timer8_compare_irq_regs #(
  parameter DIV = 1 // timer tick every DIV clocks
) (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // global interrupt enable and acknowledges from the cpu
  input wire global_irq_enable,
  input wire ack_overflow,
  input wire ack_compare_a,
  input wire ack_compare_b,
  // axi4-lite write address
  input wire [8:0] s_axi_awaddr, // byte address, four times the index
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [8:0] s_axi_araddr, // byte address, four times the index
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // interrupt requests
  output wire irq_overflow,
  output wire irq_compare_a,
  output wire irq_compare_b,
  output wire irq,
  // waveform pins
  output reg wave_pin_a,
  output reg wave_pin_b
);
  // software state
  // everything below resets to zero, so the timer comes up stopped
  // and with every request masked
  reg [7:0] compare_a_value; // compare a
  reg [7:0] compare_b_value; // compare b
  reg [2:0] timer0_irq_mask; // enables
  reg [2:0] timer0_irq_flags; // sticky flags
  reg [7:0] counter_value; // running counter
  reg [2:0] waveform_mode_sel; // counting mode
  reg tick_enable; // counter runs
  reg count_down; // phase-correct direction
  reg block_match; // set by counter write
  reg [15:0] div_cnt; // tick divider
  // bus latches: one half of a write may arrive before the other,
  // so whichever comes first is parked here until its partner shows up
  // and the write is done in one cycle once both are in hand
  reg aw_held; // address parked
  reg w_held; // data parked
  reg [8:0] aw_addr; // parked byte address
  reg [31:0] w_data; // parked data word
  reg [3:0] w_strb; // parked byte strobes

  // write channels accepted independently, response after both;
  // no new write is taken while a response waits, which keeps at most
  // one write in flight without any extra bookkeeping
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  // one read in flight: the next address waits until the data is taken
  assign s_axi_arready = !s_axi_rvalid;
  // the live channel wins over the parked copy in the cycle it is taken
  wire [8:0] wa = s_axi_awvalid && s_axi_awready ? s_axi_awaddr : aw_addr;
  wire [31:0] wd = s_axi_wvalid && s_axi_wready ? s_axi_wdata : w_data;
  wire [3:0] ws = s_axi_wvalid && s_axi_wready ? s_axi_wstrb : w_strb;
  wire have_aw = aw_held || (s_axi_awvalid && s_axi_awready);
  wire have_w = w_held || (s_axi_wvalid && s_axi_wready);
  wire do_write = have_aw && have_w && !s_axi_bvalid;
  // only byte lane 0 carries register bits
  wire wr_lane = do_write && ws[0];
  // registers sit on whole words: index from the upper bits
  wire wa_word = wa[1:0] == 2'b00;
  wire [6:0] wa_idx = wa[8:2];
  // decoded write strobes, misaligned addresses hit nothing
  wire wr_cmpa = wr_lane && wa_word && wa_idx == `OFS_COMPARE_A;
  wire wr_cmpb = wr_lane && wa_word && wa_idx == `OFS_COMPARE_B;
  wire wr_mask = wr_lane && wa_word && wa_idx == `OFS_IRQ_MASK;
  wire wr_flag = wr_lane && wa_word && wa_idx == `OFS_IRQ_FLAGS;
  wire wr_cnt = wr_lane && wa_word && wa_idx == `OFS_COUNTER;
  wire wr_ctl = wr_lane && wa_word && wa_idx == `OFS_CONTROL;
  // forced compare only meaningful outside pwm modes
  wire pwm_mode = waveform_mode_sel[0];
  wire force_a = wr_ctl && wd[`CTL_FORCE_A] && !pwm_mode;
  wire force_b = wr_ctl && wd[`CTL_FORCE_B] && !pwm_mode;

  // tick divider, one-cycle enable; the whole timer moves on this pulse
  // only, so a slower timer clock never needs a second clock domain
  localparam [15:0] DIV_LAST = DIV[15:0] - 16'h0001; // last divider count
  wire tick = tick_enable && div_cnt == DIV_LAST;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 16'h0000;
    end else if (!tick_enable || tick) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  // top of the count for current mode
  // ctc and the register-topped modes turn at compare a,
  // all others run the full byte; reserved codes fall in with ctc
  // so the counter can never stall on an undefined mode
  wire top_is_a = waveform_mode_sel[2] || waveform_mode_sel[1:0] == 2'b10;
  wire [7:0] top = top_is_a ? compare_a_value : `CNT_MAX;
  wire phase_mode = waveform_mode_sel[1:0] == 2'b01;
  // compare results, blocked after a counter write
  // without the block, software loading the counter with the compare
  // value would see a spurious event at once; the block lasts one tick
  // and is gone whether or not that tick matched
  wire match_a = tick && !block_match && counter_value == compare_a_value; // RL1 RL14
  wire match_b = tick && !block_match && counter_value == compare_b_value; // RL2 RL14
  // overflow point per mode
  // phase-correct modes flag at the bottom turn, the register-topped
  // fast mode at its top, every other mode at the byte's end
  // only evaluated on a tick, so a stopped timer raises nothing
  reg ovf_evt;
  always @* begin
    ovf_evt = 1'b0;
    if (tick) begin
      if (phase_mode) begin
        ovf_evt = counter_value == `CNT_BOTTOM && count_down; // RL13
      end else if (waveform_mode_sel == 3'b111) begin
        ovf_evt = counter_value == top; // RL13
      end else begin
        ovf_evt = counter_value == `CNT_MAX; // RL13
      end
    end
  end

  // counter; a forced compare never clears it
  // a bus write wins over the tick in the same cycle, so the value
  // written is exactly what the next tick starts from
  // count_down only matters in the phase-correct modes
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      counter_value <= `RST_BYTE;
      count_down <= 1'b0;
      block_match <= 1'b0;
    end else if (wr_cnt) begin
      counter_value <= wd[7:0];
      block_match <= 1'b1; // RL14
    end else if (tick) begin
      block_match <= 1'b0;
      if (phase_mode) begin
        // up to top, then back to bottom
        if (!count_down && counter_value == top) begin
          count_down <= 1'b1;
          counter_value <= counter_value - 8'h01;
        end else if (count_down && counter_value == `CNT_BOTTOM) begin
          count_down <= 1'b0;
          counter_value <= counter_value + 8'h01;
        end else if (count_down) begin
          counter_value <= counter_value - 8'h01;
        end else begin
          counter_value <= counter_value + 8'h01;
        end
      end else if (counter_value == top) begin
        counter_value <= `CNT_BOTTOM; // ctc or pwm wrap; RL15 force absent here
        count_down <= 1'b0;
      end else begin
        counter_value <= counter_value + 8'h01;
        count_down <= 1'b0;
      end
    end
  end

  // waveform pins: toggle on match or forced strobe
  // the strobe is ignored in pwm modes so software cannot disturb a
  // running pwm period; a blocked match leaves the pins alone too
  // both pins are registered so they never glitch
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wave_pin_a <= 1'b0;
      wave_pin_b <= 1'b0;
    end else begin
      if (match_a || force_a) begin
        wave_pin_a <= !wave_pin_a; // RL1 RL15
      end
      if (match_b || force_b) begin
        wave_pin_b <= !wave_pin_b; // RL2 RL15
      end
    end
  end

  // software registers
  // only the low byte lane is looked at; the force bits of the
  // control word are strobes and are never stored
  // mask keeps just its three live bits, the rest read zero
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      compare_a_value <= `RST_BYTE;
      compare_b_value <= `RST_BYTE;
      timer0_irq_mask <= 3'b000;
      waveform_mode_sel <= 3'b000;
      tick_enable <= 1'b0;
    end else begin
      if (wr_cmpa) begin
        compare_a_value <= wd[7:0];
      end
      if (wr_cmpb) begin
        compare_b_value <= wd[7:0]; // RL2
      end
      if (wr_mask) begin
        timer0_irq_mask <= wd[2:0];
      end
      if (wr_ctl) begin
        waveform_mode_sel <= wd[`CTL_MODE_LSB +: 3];
        tick_enable <= wd[`CTL_TICK_EN];
      end
    end
  end

  // flag set beats any clear in the same cycle
  // losing an event is worse than a spare interrupt, so a match that
  // lands with the acknowledge or a write-one-clear stays visible
  // writing zero to a flag bit leaves it as it was
  wire [2:0] set_evt = {match_b, match_a, ovf_evt}; // RL7 RL9 RL11
  wire [2:0] ack_evt = {ack_compare_b, ack_compare_a, ack_overflow}; // RL16
  wire [2:0] sw_clr = wr_flag ? wd[2:0] : 3'b000;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      timer0_irq_flags <= 3'b000;
    end else begin
      timer0_irq_flags <= set_evt | (timer0_irq_flags & ~(ack_evt | sw_clr)); // RL8 RL10 RL12
    end
  end

  // level requests to the cpu
  // combinational from registered state, so a request drops in the same
  // cycle as the flag clears and never pulses on its own
  // the global enable gates all three alike
  assign irq_compare_b = global_irq_enable && timer0_irq_mask[`BIT_CMPB]
    && timer0_irq_flags[`BIT_CMPB]; // RL4 RL16
  assign irq_compare_a = global_irq_enable && timer0_irq_mask[`BIT_CMPA]
    && timer0_irq_flags[`BIT_CMPA]; // RL5 RL16
  assign irq_overflow = global_irq_enable && timer0_irq_mask[`BIT_OVF]
    && timer0_irq_flags[`BIT_OVF]; // RL6 RL16
  assign irq = irq_compare_b || irq_compare_a || irq_overflow;

  // write handshake
  // the response is registered and stands until bready; the parked
  // halves are freed in the same cycle the write lands
  // a write with lane 0 off answers okay and changes nothing
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 9'h000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // unmapped address answers slverr
        s_axi_bresp <= (wr_cmpa || wr_cmpb || wr_mask || wr_flag || wr_cnt || wr_ctl
          || !ws[0]) ? 2'b00 : 2'b10;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // read mux; reserved bits read zero
  // decoded straight from the live address: the data is latched in the
  // same cycle the address is taken, so no address register is needed
  // unmapped or misaligned addresses answer an error with zero data
  reg [7:0] rd_byte;
  reg rd_hit;
  always @* begin
    rd_byte = 8'h00;
    rd_hit = 1'b1;
    // decode on the word index
    case (s_axi_araddr[8:2])
      `OFS_COMPARE_A: rd_byte = compare_a_value;
      `OFS_COMPARE_B: rd_byte = compare_b_value;
      `OFS_IRQ_MASK: rd_byte = {5'b00000, timer0_irq_mask}; // RL3
      `OFS_IRQ_FLAGS: rd_byte = {5'b00000, timer0_irq_flags}; // RL3
      `OFS_COUNTER: rd_byte = counter_value;
      `OFS_CONTROL: rd_byte = {4'h0, tick_enable, waveform_mode_sel}; // strobes read zero
      default: rd_hit = 1'b0;
    endcase
    if (s_axi_araddr[1:0] != 2'b00) begin
      // not on a word boundary
      rd_byte = 8'h00;
      rd_hit = 1'b0;
    end
  end

  // read handshake, answer one cycle after address
  // rdata is a flop so it holds still while rvalid waits for rready;
  // a new address is only taken once the old answer has gone
  // the register value is sampled when the address is taken
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // timer8_compare_irq_regs
`default_nettype wire

// ==== verilog/timer8_regs.vh ====
// Behaviour
// RL1: compare A against counter every timer tick
// RL2: compare B register, reset zero, matched continuously; the code compares only on a timer tick
// RL3: mask and flag bits 7..3 read zero
// RL4: mask bit 2 gates compare B request
// RL5: mask bit 1 gates compare A request
// RL6: mask bit 0 gates overflow request
// RL7: counter equals compare B sets flag 2
// RL8: compare B flag cleared by vector or one
// RL9: counter equals compare A sets flag 1
// RL10: compare A flag cleared by vector or one
// RL11: counter overflow sets flag 0
// RL12: overflow flag cleared by vector or one
// RL13: overflow point depends on waveform mode
// RL14: counter write blocks next tick's match
// RL15: forced compare toggles pin only
// RL16: level requests, one-cycle acknowledge clears flag
`ifndef TIMER8_REGS_VH
`define TIMER8_REGS_VH
// register word indices; the bus byte address is four times the index
// because some indices are not word aligned as byte addresses
`define OFS_COMPARE_B 7'h28
`define OFS_IRQ_MASK 7'h6E
`define OFS_COMPARE_A 7'h27
`define OFS_IRQ_FLAGS 7'h15
`define OFS_COUNTER 7'h26
`define OFS_CONTROL 7'h24
// field positions
`define BIT_OVF 0
`define BIT_CMPA 1
`define BIT_CMPB 2
`define CTL_MODE_LSB 0
`define CTL_FORCE_B 6
`define CTL_FORCE_A 7
`define CTL_TICK_EN 3
// reset values
`define RST_BYTE 8'h00
// counter limits
`define CNT_MAX 8'hFF
`define CNT_BOTTOM 8'h00
`endif

// ==== verif/timer8_irq_checker_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module timer8_irq_checker (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // bus answers
  input wire logic [8:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // interrupt side
  input wire logic global_irq_enable,
  input wire logic irq_overflow,
  input wire logic irq_compare_a,
  input wire logic irq_compare_b,
  input wire logic irq
);
  // single domain, so one default for all
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // no request while the cpu enable is off
  property p_ovf_gate; irq_overflow |-> global_irq_enable; endproperty
  a_ovf_gate: assert property (p_ovf_gate) else $error("overflow request ungated");
  property p_cmpa_gate; irq_compare_a |-> global_irq_enable; endproperty
  a_cmpa_gate: assert property (p_cmpa_gate) else $error("compare a request ungated");
  property p_cmpb_gate; irq_compare_b |-> global_irq_enable; endproperty
  a_cmpb_gate: assert property (p_cmpb_gate) else $error("compare b request ungated");
  // summary line is the or of the three
  property p_irq_or; irq == (irq_overflow | irq_compare_a | irq_compare_b); endproperty
  a_irq_or: assert property (p_irq_or) else $error("summary request wrong");
  // answers drop after their handshake
  property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_done: assert property (p_b_done) else $error("write answer lingers");
  property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_done: assert property (p_r_done) else $error("read answer lingers");
  // read data one cycle after address taken
  property p_r_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_ans: assert property (p_r_ans) else $error("read answer late");
  // mask and flags read reserved bits as zero
  property p_r_resv;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr == 9'h1B8 || s_axi_araddr == 9'h054)
      |=> s_axi_rdata[31:3] == 29'h0;
  endproperty
  a_r_resv: assert property (p_r_resv) else $error("reserved bits set");
  // main scenarios seen
  c_cmpa: cover property (irq_compare_a);
  c_ovf: cover property (irq_overflow);
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule // timer8_irq_checker
`default_nettype wire

// ==== verif/cpu_irq_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpu_irq_model (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // cycles before a vector is taken
  input wire logic [3:0] lat,
  // level requests
  input wire logic irq_overflow,
  input wire logic irq_compare_a,
  input wire logic irq_compare_b,
  // one-cycle acknowledges
  output logic ack_overflow,
  output logic ack_compare_a,
  output logic ack_compare_b
);
  logic [3:0] wait_cnt; // cycles waited so far
  logic [2:0] req; // pending requests
  assign req = {irq_compare_b, irq_compare_a, irq_overflow};
  // one vector at a time, lowest bit first
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {ack_compare_b, ack_compare_a, ack_overflow} <= 3'h0;
      wait_cnt <= 4'h0;
    end else if (ack_overflow | ack_compare_a | ack_compare_b | ~(|req)) begin
      // gap after a vector so the flag can drop
      {ack_compare_b, ack_compare_a, ack_overflow} <= 3'h0;
      wait_cnt <= 4'h0;
    end else if (wait_cnt == lat) begin
      {ack_compare_b, ack_compare_a, ack_overflow} <= req & (~req + 3'h1);
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule // cpu_irq_model
`default_nettype wire

// ==== verif/test_timer8_compare_irq_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "timer8_regs.vh"
module test_timer8_compare_irq_regs;
  logic clock = 1'b0, rst_n = 1'b0, gie = 1'b0; // clock, reset, cpu enable
  logic [8:0] awaddr = 9'h000, araddr = 9'h000; // bus byte addresses
  logic [7:0] v; // stimulus byte
  logic [31:0] wdata = 32'h0, d; // write data, last read data
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, p, q; // requests, pin snapshots
  logic [3:0] lat = 4'h0; // cpu vector latency
  logic [1:0] r; // last bus response
  wire awready, wready, bvalid, arready, rvalid, irq_o, irq_a, irq_b, irq;
  wire ack_o, ack_a, ack_b, pin_a, pin_b;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int mismatches = 0, total_checks = 0;
  always #10 clock = ~clock;
  // answers are always accepted at once
  timer8_compare_irq_regs #(.DIV(1)) dut (.clock(clock), .rst_n(rst_n),
    .global_irq_enable(gie), .ack_overflow(ack_o), .ack_compare_a(ack_a),
    .ack_compare_b(ack_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .irq_overflow(irq_o), .irq_compare_a(irq_a), .irq_compare_b(irq_b), .irq(irq),
    .wave_pin_a(pin_a), .wave_pin_b(pin_b));
  cpu_irq_model cpu (.clock(clock), .rst_n(rst_n), .lat(lat), .irq_overflow(irq_o),
    .irq_compare_a(irq_a), .irq_compare_b(irq_b), .ack_overflow(ack_o),
    .ack_compare_a(ack_a), .ack_compare_b(ack_b));
  // each request held until its ready is sampled high at a rising edge
  task wr(input logic [6:0] a, input logic [7:0] val);
    logic aw_on, w_on;
    aw_on = 1'b1;
    w_on = 1'b1;
    awaddr <= {a, 2'b00};
    wdata <= {24'h0, val};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (aw_on || w_on) begin
      @(posedge clock);
      if (aw_on && awready) begin
        aw_on = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_on && wready) begin
        w_on = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (!bvalid);
    r = bresp;
  endtask
  task rd(input logic [6:0] a);
    araddr <= {a, 2'b00};
    arvalid <= 1'b1;
    do @(posedge clock); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clock); while (!rvalid);
    d = rdata;
    r = rresp;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task rdc(input logic [6:0] a, input logic [31:0] exp);
    rd(a);
    chk(d, exp);
  endtask
  // only the three low mask bits exist
  function logic [31:0] mask_exp(input logic [7:0] w);
    return {29'h0, w[2:0]};
  endfunction
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // hang guard, far beyond the expected run
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    complete_run;
  end
  initial begin
    void'($urandom(32'h8D686EFD));
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rdc(`OFS_COMPARE_B, 32'h0);
    rdc(`OFS_COMPARE_A, 32'h0);
    rdc(`OFS_IRQ_MASK, 32'h0);
    rdc(`OFS_IRQ_FLAGS, 32'h0);
    rd(7'h40);
    chk({30'h0, r}, 32'h2);
    wr(7'h40, 8'h00);
    chk({30'h0, r}, 32'h2);
    // all-ones corner first, then random bytes
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 8'hFF : 8'($urandom);
      wr(`OFS_COMPARE_B, v);
      wr(`OFS_COMPARE_A, ~v);
      wr(`OFS_IRQ_MASK, v);
      rdc(`OFS_COMPARE_B, {24'h0, v});
      rdc(`OFS_COMPARE_A, {24'h0, ~v});
      rdc(`OFS_IRQ_MASK, mask_exp(v));
    end
    // full wrap with everything masked
    wr(`OFS_IRQ_MASK, 8'h00);
    wr(`OFS_COMPARE_B, 8'h40);
    wr(`OFS_COMPARE_A, 8'h90);
    wr(`OFS_CONTROL, 8'h08);
    repeat (300) @(posedge clock);
    wr(`OFS_CONTROL, 8'h00);
    rdc(`OFS_IRQ_FLAGS, 32'h7);
    wr(`OFS_IRQ_FLAGS, 8'h00);
    rdc(`OFS_IRQ_FLAGS, 32'h7);
    wr(`OFS_IRQ_FLAGS, 8'h02);
    rdc(`OFS_IRQ_FLAGS, 32'h5);
    wr(`OFS_IRQ_FLAGS, 8'h04);
    rdc(`OFS_IRQ_FLAGS, 32'h1);
    wr(`OFS_IRQ_FLAGS, 8'hF9);
    rdc(`OFS_IRQ_FLAGS, 32'h0);
    // forced compare moves the pin and nothing else
    @(negedge clock);
    p = pin_a;
    q = pin_b;
    @(posedge clock);
    wr(`OFS_CONTROL, 8'hC0);
    repeat (3) @(negedge clock);
    chk({31'h0, pin_a}, {31'h0, ~p});
    chk({31'h0, pin_b}, {31'h0, ~q});
    @(posedge clock);
    rdc(`OFS_IRQ_FLAGS, 32'h0);
    // a counter write hides the match on the very next tick
    wr(`OFS_COUNTER, 8'h90);
    wr(`OFS_CONTROL, 8'h08);
    wr(`OFS_CONTROL, 8'h00);
    rdc(`OFS_IRQ_FLAGS, 32'h0);
    // cpu services compare a only, others stay pending
    gie <= 1'b1;
    wr(`OFS_IRQ_MASK, 8'h02);
    wr(`OFS_CONTROL, 8'h08);
    repeat (300) @(posedge clock);
    wr(`OFS_CONTROL, 8'h00);
    repeat (20) @(posedge clock);
    rdc(`OFS_IRQ_FLAGS, 32'h5);
    // slow cpu then clears the rest by vector
    lat <= 4'h5;
    wr(`OFS_IRQ_MASK, 8'h07);
    repeat (40) @(posedge clock);
    rdc(`OFS_IRQ_FLAGS, 32'h0);
    @(negedge clock);
    chk({31'h0, irq}, 32'h0);
    complete_run;
  end
endmodule // test_timer8_compare_irq_regs
bind timer8_compare_irq_regs timer8_irq_checker chk (.*);
`default_nettype wire
